// ### common/async_serial_defs.vh
`ifndef ASYNC_SERIAL_DEFS_VH
`define ASYNC_SERIAL_DEFS_VH
// ----------------------------------------
// register indexes
// ----------------------------------------
`define REG_TXDATA 3'h0
`define REG_RXDATA 3'h1
`define REG_STATUS 3'h2
`define REG_CTRL 3'h3
`define REG_DIVLO 3'h4
`define REG_DIVHI 3'h5
`define REG_ADDR 3'h6
// ----------------------------------------
// control bit positions
// ----------------------------------------
`define CTL_TXEN 0
`define CTL_RXEN 1
`define CTL_FLOW 2
`define CTL_PAREN 3
`define CTL_PARODD 4
`define CTL_MDEN 5
`define CTL_MDLO 6
`define CTL_MDHI 7
`define CTL_ADRFLG 8
`define CTL_RXIEN 9
`define CTL_STOP2 10
// ----------------------------------------
// reset values and counts
// ----------------------------------------
`define CTRL_RST 11'h200
`define DIV_RST 16'h0001
`define OVS_LAST 4'hF
`define OVS_MID 4'h7
`define TX_BITS 4'hA
`define RX_BITS 4'h9
`endif

// ### src/rate_divider.v
`timescale 1ns/1ps
// ----------------------------------------
// divisor counter: tick every divisor clocks
// ----------------------------------------
module rate_divider #(
  parameter WIDTH = 16
) (
  // clock and reset
  input wire clk,
  input wire rstSync_n,
  // control
  input wire [WIDTH-1:0] divisor,
  input wire restart,
  // output
  output reg tick_ff
);
  reg [WIDTH-1:0] cnt_ff;
  wire [WIDTH-1:0] one = {{(WIDTH-1){1'b0}}, 1'b1};
  wire hit = (cnt_ff >= divisor) || (divisor == {WIDTH{1'b0}});
  always @(posedge clk or negedge rstSync_n)
  begin
    if (!rstSync_n)
    begin
      cnt_ff <= {{(WIDTH-1){1'b0}}, 1'b1};
      tick_ff <= 1'b0;
    end
    else if (restart)
    begin
      cnt_ff <= one;
      tick_ff <= 1'b0;
    end
    else
    begin
      cnt_ff <= hit ? one : cnt_ff + one;
      tick_ff <= hit;
    end
  end
endmodule

// ### src/async_serial_port_mp.v
// The implementer's own choices: the address map and the plain strobed port.
`timescale 1ns/1ps
`include "async_serial_defs.vh"
// Overview of operation
// - with flow gate enabled, clear-to-send gates each new character start
// - clear-to-send sampled one clock before start; held off while deasserted
// - a character already started is always finished
// - address flag bit sent after eight data bits, before stop bits
// - separate transmit and receive interrupt requests
// - with serial disabled, rate divider runs as timer with interrupt
// - holding empty set once first bit leaves shifter; raises tx interrupt
// - writing transmit holding register clears holding empty
// - rx interrupt on byte available, break, overrun or framing error
// - byte available interrupt maskable alone
// - data interrupt only after byte moved into holding register
// - multidrop mode: data interrupts depend on mode and last address
// - overrun keeps valid byte, new character dropped
// - overrun and line break seen hidden until pending byte read
// - after read, overrun shown and byte available set again
// - line break seen tells whether break caused overrun
// - bit rate is clock over sixteen times divisor
// - 8-bit and 9-bit formats with selectable parity
// - rate divider is a 16-bit counter usable as timer
module async_serial_port_mp #(
  parameter DIV_W = 16
) (
  // clock and reset
  input wire core_clk,
  input wire rst_n,
  // register port
  input wire [2:0] regAddr,
  input wire [15:0] regWdata,
  input wire regWr,
  input wire regRd,
  output reg [15:0] regRdata_ff,
  // serial pins
  input wire rxPin,
  input wire clearToSend_n,
  output reg txPin_ff,
  // interrupts
  output wire txIrq,
  output wire rxIrq
);
  // ----------------------------------------
  // reset release
  // ----------------------------------------
  reg [1:0] rstSync_ff;
  wire rstSync_n = rstSync_ff[1];
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      rstSync_ff <= 2'h0;
    else
      rstSync_ff <= {rstSync_ff[0], 1'b1};
  end
  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  reg [1:0] rxMeta_ff;
  reg [1:0] ctsMeta_ff;
  always @(posedge core_clk or negedge rstSync_n)
  begin
    if (!rstSync_n)
    begin
      rxMeta_ff <= 2'h3;
      ctsMeta_ff <= 2'h3;
    end
    else
    begin
      rxMeta_ff <= {rxMeta_ff[0], rxPin};
      ctsMeta_ff <= {ctsMeta_ff[0], clearToSend_n};
    end
  end
  wire rxIn = rxMeta_ff[1];
  wire ctsOk = ~ctsMeta_ff[1];
  // ----------------------------------------
  // registers
  // ----------------------------------------
  reg [10:0] ctrl_ff;
  reg [DIV_W-1:0] divisor_ff;
  reg [7:0] nodeAddr_ff;
  reg [8:0] txHold_ff;
  reg txHoldEmpty_ff;
  reg [8:0] rxHold_ff;
  reg rxByteAvail_ff;
  reg overrun_ff, overrunPend_ff, lineBreakSeen_ff, breakPend_ff;
  reg frameErr_ff, parityErr_ff, breakNow_ff, timerFlag_ff;
  wire txEn = ctrl_ff[`CTL_TXEN];
  wire rxEn = ctrl_ff[`CTL_RXEN];
  wire parEn = ctrl_ff[`CTL_PAREN];
  wire mdEn = ctrl_ff[`CTL_MDEN];
  wire [1:0] mdMode = {ctrl_ff[`CTL_MDHI], ctrl_ff[`CTL_MDLO]};
  wire serialOff = ~txEn & ~rxEn;
  wire wrCtrl = regWr && regAddr == `REG_CTRL;
  wire wrTx = regWr && regAddr == `REG_TXDATA;
  wire rdRx = regRd && regAddr == `REG_RXDATA;
  wire rdStat = regRd && regAddr == `REG_STATUS;
  // ----------------------------------------
  // rate divider: x16 tick
  // ----------------------------------------
  wire ovsTick;
  rate_divider #(.WIDTH(DIV_W)) u_div (
    .clk(core_clk),
    .rstSync_n(rstSync_n),
    .divisor(divisor_ff),
    .restart(regWr && (regAddr == `REG_DIVLO || regAddr == `REG_DIVHI)),
    .tick_ff(ovsTick)
  );
  function parityOf;
    input [8:0] d;
    input odd;
    parityOf = ^d ^ odd;
  endfunction
  // ----------------------------------------
  // transmitter
  // ----------------------------------------
  localparam TX_IDLE = 2'b01;
  localparam TX_SHIFT = 2'b10;
  reg [1:0] txState_ff;
  reg [11:0] txShift_ff;
  reg [3:0] txBits_ff, txOvs_ff;
  // frame: data bits, optional flag/parity, stop bits
  wire txExtra = mdEn | parEn;
  wire txFlag = mdEn ? txHold_ff[8] : parityOf({1'b0, txHold_ff[7:0]}, ctrl_ff[`CTL_PARODD]);
  wire [3:0] txLen = `TX_BITS + {3'h0, txExtra} + {3'h0, ctrl_ff[`CTL_STOP2]};
  always @(posedge core_clk or negedge rstSync_n)
  begin
    if (!rstSync_n)
    begin
      txState_ff <= TX_IDLE;
      txShift_ff <= 12'hFFF;
      txBits_ff <= 4'h0;
      txOvs_ff <= 4'h0;
      txPin_ff <= 1'b1;
      txHoldEmpty_ff <= 1'b1;
    end
    else
    begin
      case (txState_ff)
        TX_IDLE:
        begin
          txPin_ff <= 1'b1;
          // cts sampled in the cycle before start; start on a tick edge
          if (ovsTick && txEn && !txHoldEmpty_ff && (!ctrl_ff[`CTL_FLOW] || ctsOk))
          begin
            // flag bit directly after data, before stop
            txShift_ff <= txExtra ? {2'h3, txFlag, txHold_ff[7:0], 1'b0}
                                  : {3'h7, txHold_ff[7:0], 1'b0};
            txBits_ff <= txLen;
            txOvs_ff <= 4'h0;
            txPin_ff <= 1'b0;
            txState_ff <= TX_SHIFT;
          end
        end
        TX_SHIFT:
        begin
          // cts ignored here so the character completes
          if (ovsTick)
          begin
            txOvs_ff <= txOvs_ff + 4'h1;
            if (txOvs_ff == `OVS_LAST)
            begin
              // first bit gone: holding register free
              if (txBits_ff == txLen)
                txHoldEmpty_ff <= 1'b1;
              txShift_ff <= {1'b1, txShift_ff[11:1]};
              txPin_ff <= txShift_ff[1];
              txBits_ff <= txBits_ff - 4'h1;
              if (txBits_ff == 4'h1)
              begin
                txPin_ff <= 1'b1;
                txState_ff <= TX_IDLE;
              end
            end
          end
        end
        default:
          txState_ff <= TX_IDLE;
      endcase
      if (wrTx)
        txHoldEmpty_ff <= 1'b0;
    end
  end
  // ----------------------------------------
  // receiver
  // ----------------------------------------
  localparam RX_IDLE = 3'b001;
  localparam RX_START = 3'b010;
  localparam RX_DATA = 3'b100;
  reg [2:0] rxState_ff;
  reg [9:0] rxShift_ff;
  reg [3:0] rxBits_ff, rxOvs_ff;
  reg rxPrev_ff, rxDone_ff, addrMatch_ff;
  wire [3:0] rxLen = `RX_BITS + {3'h0, txExtra};
  // aligned frame without start: [7:0] data, [8] flag, [9] stop
  wire [9:0] rxFrame = txExtra ? rxShift_ff : {rxShift_ff[9], 1'b0, rxShift_ff[8:1]};
  wire rxIsAddr = mdEn & rxFrame[8];
  // multidrop filtering
  reg rxAccept;
  always @*
  begin
    rxAccept = 1'b1;
    if (mdEn)
    begin
      case (mdMode)
        2'h1: rxAccept = rxIsAddr | addrMatch_ff;
        2'h2: rxAccept = rxIsAddr ? (rxFrame[7:0] == nodeAddr_ff) : addrMatch_ff;
        2'h3: rxAccept = rxIsAddr ? 1'b0 : addrMatch_ff;
        default: rxAccept = 1'b1;
      endcase
    end
  end
  always @(posedge core_clk or negedge rstSync_n)
  begin
    if (!rstSync_n)
    begin
      rxState_ff <= RX_IDLE;
      rxShift_ff <= 10'h000;
      rxBits_ff <= 4'h0;
      rxOvs_ff <= 4'h0;
      rxPrev_ff <= 1'b1;
      rxDone_ff <= 1'b0;
    end
    else
    begin
      rxDone_ff <= 1'b0;
      if (ovsTick)
        rxPrev_ff <= rxIn;
      case (rxState_ff)
        RX_IDLE:
          // falling edge starts a start-bit
          if (rxEn && ovsTick && rxPrev_ff && !rxIn)
          begin
            rxOvs_ff <= 4'h0;
            rxState_ff <= RX_START;
          end
        RX_START:
          if (ovsTick)
          begin
            rxOvs_ff <= rxOvs_ff + 4'h1;
            if (rxOvs_ff == `OVS_MID - 4'h1)
            begin
              // confirmed mid-bit, else a glitch
              rxState_ff <= rxIn ? RX_IDLE : RX_DATA;
              rxOvs_ff <= 4'h0;
              rxBits_ff <= rxLen;
            end
          end
        RX_DATA:
          if (ovsTick)
          begin
            rxOvs_ff <= rxOvs_ff + 4'h1;
            if (rxOvs_ff == `OVS_LAST)
            begin
              rxShift_ff <= {rxIn, rxShift_ff[9:1]};
              rxBits_ff <= rxBits_ff - 4'h1;
              if (rxBits_ff == 4'h1)
              begin
                rxDone_ff <= 1'b1;
                rxState_ff <= RX_IDLE;
              end
            end
          end
        default:
          rxState_ff <= RX_IDLE;
      endcase
    end
  end
  // ----------------------------------------
  // receive holding and status
  // ----------------------------------------
  always @(posedge core_clk or negedge rstSync_n)
  begin
    if (!rstSync_n)
    begin
      rxHold_ff <= 9'h000;
      rxByteAvail_ff <= 1'b0;
      overrun_ff <= 1'b0;
      overrunPend_ff <= 1'b0;
      lineBreakSeen_ff <= 1'b0;
      breakPend_ff <= 1'b0;
      frameErr_ff <= 1'b0;
      parityErr_ff <= 1'b0;
      breakNow_ff <= 1'b0;
      addrMatch_ff <= 1'b0;
    end
    else
    begin
      // status read clears errors; later event sets win below
      if (rdStat)
      begin
        overrun_ff <= 1'b0;
        lineBreakSeen_ff <= 1'b0;
        frameErr_ff <= 1'b0;
        parityErr_ff <= 1'b0;
        breakNow_ff <= 1'b0;
      end
      if (rdRx)
      begin
        rxByteAvail_ff <= 1'b0;
        // reveal hidden overrun after valid byte read
        if (overrunPend_ff)
        begin
          overrun_ff <= 1'b1;
          lineBreakSeen_ff <= breakPend_ff;
          rxByteAvail_ff <= 1'b1;
          overrunPend_ff <= 1'b0;
          breakPend_ff <= 1'b0;
        end
      end
      if (rxDone_ff)
      begin
        if (rxIsAddr && mdMode != 2'h0)
          addrMatch_ff <= (rxFrame[7:0] == nodeAddr_ff);
        // low stop bit, all-zero character is a break
        if (!rxFrame[9])
        begin
          frameErr_ff <= 1'b1;
          if (rxFrame[8:0] == 9'h000)
            breakNow_ff <= 1'b1;
        end
        if (parEn && !mdEn && parityOf({1'b0, rxFrame[7:0]}, ctrl_ff[`CTL_PARODD]) != rxFrame[8])
          parityErr_ff <= 1'b1;
        if (rxAccept)
        begin
          if (rxByteAvail_ff && !rdRx)
          begin
            // keep the held byte, remember overrun
            overrunPend_ff <= 1'b1;
            breakPend_ff <= breakPend_ff | (rxFrame[9:0] == 10'h000);
          end
          else
          begin
            // byte lands in the same cycle as its interrupt
            rxHold_ff <= rxFrame[8:0];
            rxByteAvail_ff <= 1'b1;
          end
        end
      end
    end
  end
  // ----------------------------------------
  // timer flag when serial is off
  // ----------------------------------------
  always @(posedge core_clk or negedge rstSync_n)
  begin
    if (!rstSync_n)
    begin
      timerFlag_ff <= 1'b0;
    end
    else
    begin
      if (rdStat)
        timerFlag_ff <= 1'b0;
      // divider runs as a plain timer
      if (serialOff && ovsTick)
        timerFlag_ff <= 1'b1;
    end
  end
  // ----------------------------------------
  // interrupts
  // ----------------------------------------
  assign txIrq = (txEn & txHoldEmpty_ff) | (serialOff & timerFlag_ff);
  assign rxIrq = rxEn & ((rxByteAvail_ff & ctrl_ff[`CTL_RXIEN])
                 | overrun_ff | breakNow_ff | frameErr_ff);
  // ----------------------------------------
  // register port
  // ----------------------------------------
  always @(posedge core_clk or negedge rstSync_n)
  begin
    if (!rstSync_n)
    begin
      ctrl_ff <= `CTRL_RST;
      divisor_ff <= `DIV_RST;
      nodeAddr_ff <= 8'h00;
      txHold_ff <= 9'h000;
      regRdata_ff <= 16'h0000;
    end
    else
    begin
      if (wrCtrl)
        ctrl_ff <= regWdata[10:0];
      if (regWr && regAddr == `REG_DIVLO)
        divisor_ff[7:0] <= regWdata[7:0];
      if (regWr && regAddr == `REG_DIVHI)
        divisor_ff[DIV_W-1:8] <= regWdata[DIV_W-9:0];
      if (regWr && regAddr == `REG_ADDR)
        nodeAddr_ff <= regWdata[7:0];
      if (wrTx)
        txHold_ff <= {ctrl_ff[`CTL_ADRFLG], regWdata[7:0]};
      regRdata_ff <= 16'h0000;
      if (regRd)
      begin
        case (regAddr)
          `REG_TXDATA: regRdata_ff <= {7'h00, txHold_ff};
          `REG_RXDATA: regRdata_ff <= {7'h00, rxHold_ff};
          `REG_STATUS: regRdata_ff <= {7'h00, timerFlag_ff, addrMatch_ff, parityErr_ff,
                                      frameErr_ff, breakNow_ff, lineBreakSeen_ff,
                                      overrun_ff, txHoldEmpty_ff, rxByteAvail_ff};
          `REG_CTRL: regRdata_ff <= {5'h00, ctrl_ff};
          `REG_DIVLO: regRdata_ff <= {8'h00, divisor_ff[7:0]};
          `REG_DIVHI: regRdata_ff <= {8'h00, divisor_ff[DIV_W-1:8]};
          `REG_ADDR: regRdata_ff <= {8'h00, nodeAddr_ff};
          default: regRdata_ff <= 16'h0000;
        endcase
      end
    end
  end
endmodule

// ### tb/serial_node.sv
`timescale 1ns/1ps
// ----
// remote serial node
// ----
module serial_node (
  // clock
  input wire logic clk,
  // serial lines
  input wire logic txLine,
  output logic rxLine,
  output logic ctsN
);
  int bitLen = 16; // exact rate, no error
  int nFrames = 0;
  int i;
  logic [8:0] frames [0:15];
  logic [8:0] shiftIn;
  logic [1:0] ninthBit = 2'b00; // [1] send a ninth bit, [0] its level
  initial
  begin
    rxLine = 1'b1;
    ctsN = 1'b0; // bench raises it a clock or more before a start
  end
  // start, 8 data, then ninth bit or stop
  initial
  begin
    forever
    begin
      @(negedge txLine);
      repeat (bitLen / 2) @(posedge clk);
      for (i = 0; i < 9; i++)
      begin
        repeat (bitLen) @(posedge clk);
        shiftIn[i] = txLine;
      end
      frames[nFrames] = shiftIn;
      nFrames++;
    end
  end
  // start, 8 data lsb first, chosen stop level
  task sendChar(input logic [7:0] d, input logic stopBit);
    int k;
    begin
      rxLine <= 1'b0;
      repeat (bitLen) @(posedge clk);
      for (k = 0; k < 8; k++)
      begin
        rxLine <= d[k];
        repeat (bitLen) @(posedge clk);
      end
      if (ninthBit[1])
      begin
        rxLine <= ninthBit[0];
        repeat (bitLen) @(posedge clk);
      end
      rxLine <= stopBit;
      repeat (bitLen) @(posedge clk);
      rxLine <= 1'b1;
      repeat (bitLen * 2) @(posedge clk);
    end
  endtask
endmodule

// ### tb/async_serial_port_mp_monitor.sv
`timescale 1ns/1ps
`include "async_serial_defs.vh"
module async_serial_port_mp_monitor #(
  parameter DIV_W = 16
) (
  // clock and reset
  input wire core_clk,
  input wire rst_n,
  // register port
  input wire [2:0] regAddr,
  input wire [15:0] regWdata,
  input wire regWr,
  input wire regRd,
  input wire [15:0] regRdata_ff,
  // serial pins
  input wire rxPin,
  input wire clearToSend_n,
  input wire txPin_ff,
  // interrupts
  input wire txIrq,
  input wire rxIrq
);
  // ----
  // shadow of control and tx frame position
  // ----
  reg [10:0] ctl_ff;
  reg [DIV_W-1:0] div_ff;
  reg [DIV_W+7:0] cnt_ff;
  reg txPrev_ff;
  wire [DIV_W+7:0] bitLen = {4'h0, div_ff | (div_ff == 0), 4'h0};
  wire [3:0] nBits = 4'hA + {3'h0, ctl_ff[3] | ctl_ff[5]} + {3'h0, ctl_ff[10]};
  wire [DIV_W+7:0] frameLen = bitLen * nBits;
  wire startFall = txPrev_ff && !txPin_ff && cnt_ff == 0;
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctl_ff <= `CTRL_RST;
      div_ff <= `DIV_RST;
      cnt_ff <= {(DIV_W+8){1'b0}};
      txPrev_ff <= 1'b1;
    end
    else
    begin
      txPrev_ff <= txPin_ff;
      if (regWr && regAddr == `REG_CTRL)
        ctl_ff <= regWdata[10:0];
      if (regWr && regAddr == `REG_DIVLO)
        div_ff[7:0] <= regWdata[7:0];
      if (regWr && regAddr == `REG_DIVHI)
        div_ff[15:8] <= regWdata[7:0];
      if (startFall)
        cnt_ff <= frameLen - 1'b1;
      else if (cnt_ff != 0)
        cnt_ff <= cnt_ff - 1'b1;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  a_cts_gate: assert property ((ctl_ff[2] && clearToSend_n)[*8] |-> !startFall)
    else $error("start while clear-to-send off");
  a_bit_edges: assert property (cnt_ff != 0 && txPin_ff != txPrev_ff |-> cnt_ff % bitLen == 0)
    else $error("tx edge off bit boundary");
  a_stop_high: assert property (cnt_ff == 1 |-> txPin_ff)
    else $error("frame ends without stop");
  a_md_flag: assert property (ctl_ff[5] && cnt_ff == frameLen - bitLen * 9 - (bitLen >> 1)
    |-> txPin_ff == ctl_ff[8])
    else $error("ninth bit differs from flag");
  a_thr_clear: assert property (regWr && regAddr == `REG_TXDATA && ctl_ff[0] |=> !txIrq)
    else $error("empty not cleared by write");
  a_thr_set: assert property (startFall && ctl_ff[0] && bitLen == 16
    |-> (!txIrq)[*8] ##[1:20] txIrq)
    else $error("empty not set after start bit");
  a_rx_enable: assert property (rxIrq |-> ctl_ff[1])
    else $error("rx irq while rx off");
  a_txirq_off: assert property (!ctl_ff[0] && ctl_ff[1] |-> !txIrq)
    else $error("tx irq while tx off");
  a_avail_irq: assert property ($past(regRd && regAddr == `REG_STATUS) && regRdata_ff[0]
    && ctl_ff[9] && ctl_ff[1] |-> rxIrq)
    else $error("byte available without rx irq");
  c_tx_start: cover property (startFall);
  c_rx_irq: cover property ($rose(rxIrq));
  c_timer: cover property (!ctl_ff[0] && !ctl_ff[1] && txIrq);
endmodule
bind async_serial_port_mp async_serial_port_mp_monitor #(.DIV_W(DIV_W)) mon (
  .core_clk(core_clk), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata),
  .regWr(regWr), .regRd(regRd), .regRdata_ff(regRdata_ff), .rxPin(rxPin),
  .clearToSend_n(clearToSend_n), .txPin_ff(txPin_ff), .txIrq(txIrq), .rxIrq(rxIrq));

// ### tb/async_serial_port_mp_tb_top.sv
`timescale 1ns/1ps
`include "async_serial_defs.vh"
module async_serial_port_mp_tb_top;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] regAddr = 3'h0;
  logic [15:0] regWdata = 16'h0000;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [15:0] regRdata;
  logic rxLine, ctsN, txPin, txIrq, rxIrq;
  logic [15:0] v;
  logic [15:0] nineCtl [0:3] = '{16'h0121, 16'h0021, 16'h0009, 16'h0019};
  logic [3:0] nineExp = 4'b1001;
  int n_fail = 0;
  int comparisons = 0;
  int k, k2;
  async_serial_port_mp dut (.core_clk(core_clk), .rst_n(rst_n), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata_ff(regRdata),
    .rxPin(rxLine), .clearToSend_n(ctsN), .txPin_ff(txPin), .txIrq(txIrq), .rxIrq(rxIrq));
  serial_node node (.clk(core_clk), .txLine(txPin), .rxLine(rxLine), .ctsN(ctsN));
  initial
  begin
    forever #2.5 core_clk = ~core_clk;
  end
  // ----
  // bus, compare and wait tasks
  // ----
  task final_report;
    begin
      $display("comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  task chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    begin
      comparisons++;
      if (got !== exp)
      begin
        n_fail++;
        $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
    end
  endtask
  task wr(input logic [2:0] a, input logic [15:0] d);
    begin
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'b1;
      @(posedge core_clk);
      regWr <= 1'b0;
      @(posedge core_clk);
    end
  endtask
  task rd(input logic [2:0] a);
    begin
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge core_clk);
      regRd <= 1'b0;
      #1 v = regRdata;
      @(posedge core_clk);
    end
  endtask
  function logic cond(input int sel, input int n);
    cond = sel == 0 ? txIrq === 1'b1 : sel == 1 ? rxIrq === 1'b1 : node.nFrames >= n;
  endfunction
  task waitFor(input int sel, input int n);
    begin
      for (k = 0; k < 4000 && !cond(sel, n); k++)
        @(posedge core_clk);
      if (!cond(sel, n))
      begin
        n_fail++;
        $display("[ERR] wait %0d expected 1 seen 0", sel);
        final_report;
      end
    end
  endtask
  // ----
  // main sequence
  // ----
  initial
  begin
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    wr(3'h7, 16'hFFFF);
    rd(3'h7);
    chk("unmapped", 16'h0000, v);
    rd(`REG_CTRL);
    chk("ctrl reset", 16'h0200, v);
    chk("rx irq idle", 16'h0000, {15'h0, rxIrq});
    wr(`REG_DIVLO, 16'h0004);
    wr(`REG_CTRL, 16'h0002);
    chk("tx irq off", 16'h0000, {15'h0, txIrq});
    rd(`REG_STATUS);
    rd(`REG_STATUS);
    chk("timer cleared", 16'h0000, v & 16'h0100);
    wr(`REG_CTRL, 16'h0000);
    waitFor(0, 0);
    rd(`REG_STATUS);
    chk("timer flag", 16'h0100, v & 16'h0100);
    wr(`REG_DIVLO, 16'h0002);
    node.bitLen = 32;
    wr(`REG_CTRL, 16'h0201);
    wr(`REG_TXDATA, 16'h00A5);
    chk("empty cleared", 16'h0000, {15'h0, txIrq});
    waitFor(0, 0);
    wr(`REG_TXDATA, 16'h003C);
    waitFor(2, 2);
    chk("tx frame 0", 16'h01A5, {7'h0, node.frames[0]});
    chk("tx frame 1", 16'h013C, {7'h0, node.frames[1]});
    repeat (40) @(posedge core_clk);
    wr(`REG_DIVLO, 16'h0001);
    node.bitLen = 16;
    node.ctsN <= 1'b1;
    wr(`REG_CTRL, 16'h0205);
    wr(`REG_TXDATA, 16'h005A);
    repeat (200) @(posedge core_clk);
    chk("held off", 16'h0002, node.nFrames[15:0]);
    node.ctsN <= 1'b0;
    repeat (30) @(posedge core_clk);
    node.ctsN <= 1'b1;
    waitFor(2, 3);
    chk("flow frame", 16'h015A, {7'h0, node.frames[2]});
    node.ctsN <= 1'b0;
    for (k2 = 0; k2 < 4; k2++)
    begin
      repeat (40) @(posedge core_clk);
      wr(`REG_CTRL, nineCtl[k2]);
      wr(`REG_TXDATA, 16'h00A5);
      waitFor(2, k2 + 4);
      chk("ninth bit", {7'h0, nineExp[k2], 8'hA5}, {7'h0, node.frames[k2 + 3]});
    end
    repeat (40) @(posedge core_clk);
    wr(`REG_CTRL, 16'h0202);
    node.sendChar(8'h96, 1'b1);
    waitFor(1, 0);
    rd(`REG_RXDATA);
    chk("rx byte", 16'h0096, v & 16'h00FF);
    chk("rx irq clear", 16'h0000, {15'h0, rxIrq});
    wr(`REG_CTRL, 16'h0002);
    node.sendChar(8'h11, 1'b1);
    chk("masked avail", 16'h0000, {15'h0, rxIrq});
    rd(`REG_RXDATA);
    chk("masked byte", 16'h0011, v & 16'h00FF);
    node.sendChar(8'h55, 1'b0);
    waitFor(1, 0);
    rd(`REG_STATUS);
    chk("framing", 16'h0020, v & 16'h0030);
    rd(`REG_RXDATA);
    wr(`REG_CTRL, 16'h0202);
    node.sendChar(8'h12, 1'b1);
    node.sendChar(8'h34, 1'b1);
    rd(`REG_STATUS);
    chk("overrun hidden", 16'h0001, v & 16'h000D);
    rd(`REG_RXDATA);
    chk("kept byte", 16'h0012, v & 16'h00FF);
    rd(`REG_STATUS);
    chk("overrun shown", 16'h0005, v & 16'h000D);
    node.sendChar(8'h00, 1'b0);
    rd(`REG_RXDATA);
    rd(`REG_STATUS);
    chk("break overrun", 16'h000D, v & 16'h000D);
    chk("break", 16'h0030, v & 16'h0030);
    rd(`REG_RXDATA);
    wr(`REG_ADDR, 16'h0042);
    wr(`REG_CTRL, 16'h02A2);
    node.ninthBit = 2'b11;
    node.sendChar(8'h17, 1'b1);
    node.ninthBit = 2'b10;
    node.sendChar(8'h99, 1'b1);
    chk("other node", 16'h0000, {15'h0, rxIrq});
    node.ninthBit = 2'b11;
    node.sendChar(8'h42, 1'b1);
    rd(`REG_RXDATA);
    chk("own address", 16'h0142, v & 16'h01FF);
    node.ninthBit = 2'b10;
    node.sendChar(8'h77, 1'b1);
    rd(`REG_RXDATA);
    chk("own data", 16'h0077, v & 16'h01FF);
    final_report;
  end
endmodule
